// ===== hdl/logger_pkg.sv
// Constants, register map and carrier types of the triggered data logger.
// Assumes a 16-bit word register port and a 50 MHz system clock.
package logger_pkg;

  // Register word addresses; a 32-bit register is two words, upper half first
  localparam logic [15:0] ADDR_RUN        = 16'h9DED;
  localparam logic [15:0] ADDR_POST_PCT   = 16'h9DEE;
  localparam logic [15:0] ADDR_INTERVAL   = 16'h9DEF;
  localparam logic [15:0] ADDR_EN_LOW     = 16'h9DF0;
  localparam logic [15:0] ADDR_EN_HIGH    = 16'h9DF2;
  localparam logic [15:0] ADDR_MODE       = 16'h9DF4;
  localparam logic [15:0] ADDR_CMP1_KIND  = 16'h9DF5;
  localparam logic [15:0] ADDR_CMP1_INDEX = 16'h9DF6;
  localparam logic [15:0] ADDR_CMP1_MASK  = 16'h9DF7;
  localparam logic [15:0] ADDR_CMP1_REF   = 16'h9DF9;
  localparam logic [15:0] ADDR_CMP2_KIND  = 16'h9DFB;
  localparam logic [15:0] ADDR_CMP2_INDEX = 16'h9DFC;
  localparam logic [15:0] ADDR_CMP2_MASK  = 16'h9DFD;
  localparam logic [15:0] ADDR_CMP2_REF   = 16'h9DFF;
  // Own registers sit past the second half of the last comparator reference
  localparam logic [15:0] ADDR_STATUS     = 16'h9E01;
  localparam logic [15:0] ADDR_FREEZE_PTR = 16'h9E02;

  // Reset values
  localparam logic [15:0] RST_WORD16 = 16'h0000;
  localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
  localparam logic [31:0] RST_MASK   = 32'hFFFF_FFFF;

  // Buffer and parameter layout
  localparam logic [15:0] BUF_WORDS     = 16'hF900;              // 63,744 words
  localparam logic [63:0] DEFINED_MASK  = 64'h003F_FFFF_FFFF_FFFF; // Bits 0..53
  localparam logic [63:0] WIDE_MASK     = 64'h001C_0000_0000_0002; // 32-bit parameters
  localparam logic [6:0]  PCT_FULL      = 7'h64;                 // 100 percent
  localparam logic [15:0] RUN_ON        = 16'h0001;

  // Timing: the interval register counts milliseconds
  localparam int MS_TIME_NS    = 1000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

  // Trigger modes and compare kinds
  localparam logic [15:0] MODE_CONT = 16'h0000;
  localparam logic [15:0] MODE_ONE  = 16'h0001;
  localparam logic [15:0] MODE_OR   = 16'h0002;
  localparam logic [15:0] MODE_AND  = 16'h0003;
  localparam logic [15:0] KIND_LT   = 16'h0000;
  localparam logic [15:0] KIND_GT   = 16'h0001;
  localparam logic [15:0] KIND_EQ   = 16'h0002;
  localparam logic [15:0] KIND_NE   = 16'h0003;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_POST  = 2'b10,
    ST_DONE  = 2'b11
  } log_state_type;

  typedef struct packed {
    logic [15:0] kind;
    logic [15:0] index;
    logic [31:0] mask;
    logic [31:0] reference;
  } cmp_cfg_type;

endpackage

// ===== hdl/data_logger.sv
// Triggered data logger: samples chosen parameters into a circular buffer.
// Assumes parameter values arrive synchronous to clock, zero-extended to 32 bits.
`timescale 1ns/1ns

// One trigger comparator: mask the chosen parameter, then compare
module trig_compare (
  input  wire logic                      [63:0][31:0] values, // Sampled parameters
  input  wire logger_pkg::cmp_cfg_type                cfg,    // Comparator setup
  output logic                                        hit     // Condition true
);
  logic [31:0] chosen;
  logic [31:0] masked;

  // Select by enable-bit index and apply the mask always
  assign chosen = values[cfg.index[5:0]];
  assign masked = chosen & cfg.mask;

  // Compare kinds; unknown codes never fire
  always_comb begin
    case (cfg.kind)
      logger_pkg::KIND_LT: hit = masked < cfg.reference;
      logger_pkg::KIND_GT: hit = masked > cfg.reference;
      logger_pkg::KIND_EQ: hit = masked == cfg.reference;
      logger_pkg::KIND_NE: hit = masked != cfg.reference;
      default:             hit = 1'b0;
    endcase
  end
endmodule

module data_logger #(
  parameter int TICK_CYCLES = logger_pkg::MS_CYCLES          // Clocks per millisecond
) (
  input  wire logic              clock,      // System clock, 50 MHz
  input  wire logic              resetn,     // Asynchronous reset, active low
  input  wire logic [15:0]       reg_addr,   // Register word address
  input  wire logic [15:0]       reg_wdata,  // Register write data
  input  wire logic              reg_wr,     // Write strobe
  input  wire logic              reg_rd,     // Read strobe
  output logic      [15:0]       reg_rdata,  // Read data, cycle after strobe
  input  wire logic [63:0][31:0] param_in,   // Live parameter values
  input  wire logic [15:0]       buf_addr,   // Buffer read word address
  output logic      [15:0]       buf_data,   // Buffer word, cycle after address
  output logic      [1:0]        log_status  // Logger state, same code as status
);

  // Configuration registers
  logic [15:0]             run_r;
  logic [15:0]             post_pct_r;
  logic [15:0]             interval_r;
  logic [63:0]             enable_r;
  logic [15:0]             mode_r;
  logger_pkg::cmp_cfg_type cmp1_r;
  logger_pkg::cmp_cfg_type cmp2_r;
  logic [15:0]             rdata_r;

  // Capture state
  logger_pkg::log_state_type state_r;
  logic [63:0][31:0]         snap_r;
  logic                      busy_r;
  logic [5:0]                idx_r;
  logic                      half_r;
  logic [15:0]               wptr_r;
  logic [15:0]               words_used_r;
  logic [15:0]               post_left_r;
  logic [15:0]               post_total_r;
  logic [15:0]               freeze_ptr_r;
  logic [15:0]               tick_cnt_r;
  logic [15:0]               ms_cnt_r;
  logic [15:0]               mem [0:63743];
  logic [15:0]               buf_data_r;

  // Decode of register writes
  wire wr_run   = reg_wr && (reg_addr == logger_pkg::ADDR_RUN);
  wire wr_pct   = reg_wr && (reg_addr == logger_pkg::ADDR_POST_PCT);
  wire wr_intv  = reg_wr && (reg_addr == logger_pkg::ADDR_INTERVAL);
  wire wr_en0h  = reg_wr && (reg_addr == logger_pkg::ADDR_EN_LOW);
  wire wr_en0l  = reg_wr && (reg_addr == logger_pkg::ADDR_EN_LOW + 16'h0001);
  wire wr_en1h  = reg_wr && (reg_addr == logger_pkg::ADDR_EN_HIGH);
  wire wr_en1l  = reg_wr && (reg_addr == logger_pkg::ADDR_EN_HIGH + 16'h0001);
  wire wr_mode  = reg_wr && (reg_addr == logger_pkg::ADDR_MODE);
  wire wr_c1k   = reg_wr && (reg_addr == logger_pkg::ADDR_CMP1_KIND);
  wire wr_c1i   = reg_wr && (reg_addr == logger_pkg::ADDR_CMP1_INDEX);
  wire wr_c1mh  = reg_wr && (reg_addr == logger_pkg::ADDR_CMP1_MASK);
  wire wr_c1ml  = reg_wr && (reg_addr == logger_pkg::ADDR_CMP1_MASK + 16'h0001);
  wire wr_c1rh  = reg_wr && (reg_addr == logger_pkg::ADDR_CMP1_REF);
  wire wr_c1rl  = reg_wr && (reg_addr == logger_pkg::ADDR_CMP1_REF + 16'h0001);
  wire wr_c2k   = reg_wr && (reg_addr == logger_pkg::ADDR_CMP2_KIND);
  wire wr_c2i   = reg_wr && (reg_addr == logger_pkg::ADDR_CMP2_INDEX);
  wire wr_c2mh  = reg_wr && (reg_addr == logger_pkg::ADDR_CMP2_MASK);
  wire wr_c2ml  = reg_wr && (reg_addr == logger_pkg::ADDR_CMP2_MASK + 16'h0001);
  wire wr_c2rh  = reg_wr && (reg_addr == logger_pkg::ADDR_CMP2_REF);
  wire wr_c2rl  = reg_wr && (reg_addr == logger_pkg::ADDR_CMP2_REF + 16'h0001);

  // Start and stop requests from the run register
  wire start_req = wr_run && (reg_wdata == logger_pkg::RUN_ON)
                   && (state_r == logger_pkg::ST_IDLE || state_r == logger_pkg::ST_DONE);
  wire stop_req  = wr_run && (reg_wdata != logger_pkg::RUN_ON);
  wire running   = (run_r == logger_pkg::RUN_ON);

  // Configuration writes; a 32-bit register takes its halves separately
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      run_r      <= logger_pkg::RST_WORD16;
      post_pct_r <= logger_pkg::RST_WORD16;
      interval_r <= logger_pkg::RST_WORD16;
      enable_r   <= {logger_pkg::RST_WORD32, logger_pkg::RST_WORD32};
      mode_r     <= logger_pkg::RST_WORD16;
      cmp1_r     <= {logger_pkg::RST_WORD16, logger_pkg::RST_WORD16,
                     logger_pkg::RST_MASK, logger_pkg::RST_WORD32};
      cmp2_r     <= {logger_pkg::RST_WORD16, logger_pkg::RST_WORD16,
                     logger_pkg::RST_MASK, logger_pkg::RST_WORD32};
    end else begin
      if (wr_run)  run_r      <= reg_wdata;
      if (wr_pct)  post_pct_r <= reg_wdata;
      if (wr_intv) interval_r <= reg_wdata;
      if (wr_en0h) enable_r[31:16] <= reg_wdata;
      if (wr_en0l) enable_r[15:0]  <= reg_wdata;
      if (wr_en1h) enable_r[63:48] <= reg_wdata;
      if (wr_en1l) enable_r[47:32] <= reg_wdata;
      if (wr_mode) mode_r     <= reg_wdata;
      if (wr_c1k)  cmp1_r.kind  <= reg_wdata;
      if (wr_c1i)  cmp1_r.index <= reg_wdata;
      if (wr_c1mh) cmp1_r.mask[31:16]      <= reg_wdata;
      if (wr_c1ml) cmp1_r.mask[15:0]       <= reg_wdata;
      if (wr_c1rh) cmp1_r.reference[31:16] <= reg_wdata;
      if (wr_c1rl) cmp1_r.reference[15:0]  <= reg_wdata;
      if (wr_c2k)  cmp2_r.kind  <= reg_wdata;
      if (wr_c2i)  cmp2_r.index <= reg_wdata;
      if (wr_c2mh) cmp2_r.mask[31:16]      <= reg_wdata;
      if (wr_c2ml) cmp2_r.mask[15:0]       <= reg_wdata;
      if (wr_c2rh) cmp2_r.reference[31:16] <= reg_wdata;
      if (wr_c2rl) cmp2_r.reference[15:0]  <= reg_wdata;
    end
  end

  // Read selection, answered one cycle after the strobe
  wire [15:0] rd_sel =
    (reg_addr == logger_pkg::ADDR_RUN)                      ? run_r :
    (reg_addr == logger_pkg::ADDR_POST_PCT)                 ? post_pct_r :
    (reg_addr == logger_pkg::ADDR_INTERVAL)                 ? interval_r :
    (reg_addr == logger_pkg::ADDR_EN_LOW)                   ? enable_r[31:16] :
    (reg_addr == logger_pkg::ADDR_EN_LOW + 16'h0001)        ? enable_r[15:0] :
    (reg_addr == logger_pkg::ADDR_EN_HIGH)                  ? enable_r[63:48] :
    (reg_addr == logger_pkg::ADDR_EN_HIGH + 16'h0001)       ? enable_r[47:32] :
    (reg_addr == logger_pkg::ADDR_MODE)                     ? mode_r :
    (reg_addr == logger_pkg::ADDR_CMP1_KIND)                ? cmp1_r.kind :
    (reg_addr == logger_pkg::ADDR_CMP1_INDEX)               ? cmp1_r.index :
    (reg_addr == logger_pkg::ADDR_CMP1_MASK)                ? cmp1_r.mask[31:16] :
    (reg_addr == logger_pkg::ADDR_CMP1_MASK + 16'h0001)     ? cmp1_r.mask[15:0] :
    (reg_addr == logger_pkg::ADDR_CMP1_REF)                 ? cmp1_r.reference[31:16] :
    (reg_addr == logger_pkg::ADDR_CMP1_REF + 16'h0001)      ? cmp1_r.reference[15:0] :
    (reg_addr == logger_pkg::ADDR_CMP2_KIND)                ? cmp2_r.kind :
    (reg_addr == logger_pkg::ADDR_CMP2_INDEX)               ? cmp2_r.index :
    (reg_addr == logger_pkg::ADDR_CMP2_MASK)                ? cmp2_r.mask[31:16] :
    (reg_addr == logger_pkg::ADDR_CMP2_MASK + 16'h0001)     ? cmp2_r.mask[15:0] :
    (reg_addr == logger_pkg::ADDR_CMP2_REF)                 ? cmp2_r.reference[31:16] :
    (reg_addr == logger_pkg::ADDR_CMP2_REF + 16'h0001)      ? cmp2_r.reference[15:0] :
    (reg_addr == logger_pkg::ADDR_STATUS)                   ? {14'h0000, state_r} :
    (reg_addr == logger_pkg::ADDR_FREEZE_PTR)               ? freeze_ptr_r :
    16'h0000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rdata_r <= logger_pkg::RST_WORD16;
    else if (reg_rd) rdata_r <= rd_sel;
    else rdata_r <= logger_pkg::RST_WORD16;
  end

  assign reg_rdata  = rdata_r;
  assign log_status = state_r;

  // Words per sample: one per narrow, two per wide parameter
  logic [63:0] en_valid;
  logic [6:0]  k_words;
  assign en_valid = enable_r & logger_pkg::DEFINED_MASK;
  always_comb begin
    k_words = 7'h00;
    for (int i = 0; i < 64; i++) begin
      k_words = k_words + {6'h00, en_valid[i]} + {6'h00, en_valid[i] & logger_pkg::WIDE_MASK[i]};
    end
  end

  // Capacity in samples and the post-trigger share of it
  wire [6:0]  k_safe   = (k_words == 7'h00) ? 7'h01 : k_words;
  wire [15:0] cap_calc = logger_pkg::BUF_WORDS / {9'h000, k_safe};
  wire [22:0] used_w   = cap_calc * k_safe;
  wire [6:0]  pct_clip = (post_pct_r > {9'h000, logger_pkg::PCT_FULL}) ?
                         logger_pkg::PCT_FULL : post_pct_r[6:0];
  wire [22:0] post_mul = cap_calc * pct_clip;
  wire [22:0] post_div = post_mul / 23'h000064;

  // Millisecond tick and interval counter
  wire ms_tick     = (tick_cnt_r == 16'(TICK_CYCLES - 1));
  wire [15:0] intv = (interval_r == 16'h0000) ? 16'h0001 : interval_r;
  wire capturing   = (state_r == logger_pkg::ST_ARMED) || (state_r == logger_pkg::ST_POST);
  wire sample_tick = ms_tick && (ms_cnt_r == intv - 16'h0001) && capturing && running;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= 16'h0000;
      ms_cnt_r   <= 16'h0000;
    end else if (!capturing || start_req) begin
      tick_cnt_r <= 16'h0000;
      ms_cnt_r   <= 16'h0000;
    end else begin
      tick_cnt_r <= ms_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
      if (ms_tick) ms_cnt_r <= (ms_cnt_r == intv - 16'h0001) ? 16'h0000 : ms_cnt_r + 16'h0001;
    end
  end

  // Trigger evaluation on the stored sample
  logic hit1;
  logic hit2;
  trig_compare u_cmp1 (.values(snap_r), .cfg(cmp1_r), .hit(hit1));
  trig_compare u_cmp2 (.values(snap_r), .cfg(cmp2_r), .hit(hit2));

  logic trig_fire;
  always_comb begin
    case (mode_r)
      logger_pkg::MODE_ONE: trig_fire = running && hit1;
      logger_pkg::MODE_OR:  trig_fire = running && (hit1 || hit2);
      logger_pkg::MODE_AND: trig_fire = running && hit1 && hit2;
      default:              trig_fire = 1'b0;
    endcase
  end

  // Word sequencer: ascending enable order, upper word of wide first
  wire cur_en    = en_valid[idx_r];
  wire cur_wide  = logger_pkg::WIDE_MASK[idx_r];
  wire word_we   = busy_r && cur_en;
  wire [15:0] word_val = (cur_wide && !half_r) ? snap_r[idx_r][31:16] : snap_r[idx_r][15:0];
  wire step_idx  = busy_r && (!cur_en || !cur_wide || half_r);
  wire last_step = step_idx && (idx_r == 6'h3F);
  wire [15:0] wptr_inc = (wptr_r + 16'h0001 == words_used_r) ? 16'h0000 : wptr_r + 16'h0001;

  always_ff @(posedge clock) begin
    if (word_we) mem[wptr_r] <= word_val;
    buf_data_r <= mem[buf_addr];
  end
  assign buf_data = buf_data_r;

  // Snapshot and word walk
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      snap_r <= '0;
      busy_r <= 1'b0;
      idx_r  <= 6'h00;
      half_r <= 1'b0;
    end else if (stop_req) begin
      busy_r <= 1'b0;
    end else if (sample_tick && !busy_r) begin
      snap_r <= param_in;
      busy_r <= 1'b1;
      idx_r  <= 6'h00;
      half_r <= 1'b0;
    end else if (busy_r) begin
      half_r <= word_we && cur_wide && !half_r;
      if (step_idx) idx_r <= idx_r + 6'h01;
      if (last_step) busy_r <= 1'b0;
    end
  end

  // Capture state, circular pointer and post-trigger count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r      <= logger_pkg::ST_IDLE;
      wptr_r       <= 16'h0000;
      words_used_r <= logger_pkg::BUF_WORDS;
      post_left_r  <= 16'h0000;
      post_total_r <= 16'h0000;
      freeze_ptr_r <= 16'h0000;
    end else if (start_req && k_words != 7'h00) begin
      state_r      <= logger_pkg::ST_ARMED;
      wptr_r       <= 16'h0000;
      words_used_r <= used_w[15:0];
      post_total_r <= post_div[15:0];
    end else if (stop_req) begin
      if (state_r != logger_pkg::ST_DONE) state_r <= logger_pkg::ST_IDLE;
    end else begin
      if (word_we) wptr_r <= wptr_inc;
      if (last_step) begin
        case (state_r)
          logger_pkg::ST_ARMED: begin
            if (trig_fire) begin
              if (post_total_r == 16'h0000) begin
                state_r      <= logger_pkg::ST_DONE;
                freeze_ptr_r <= word_we ? wptr_inc : wptr_r;
              end else begin
                state_r     <= logger_pkg::ST_POST;
                post_left_r <= post_total_r;
              end
            end
          end
          logger_pkg::ST_POST: begin
            post_left_r <= post_left_r - 16'h0001;
            if (post_left_r == 16'h0001) begin
              state_r      <= logger_pkg::ST_DONE;
              freeze_ptr_r <= word_we ? wptr_inc : wptr_r;
            end
          end
          default: state_r <= state_r;
        endcase
      end
    end
  end

endmodule

// ===== test/data_logger_properties.sv
// Checker for the data logger's register port and capture state.
// Assumes it is bound to data_logger and sees only that module's ports.
`timescale 1ns/1ns
module data_logger_properties #(
  parameter int TICK_CYCLES = logger_pkg::MS_CYCLES  // Clocks per millisecond
) (
  input  wire logic              clock,      // System clock
  input  wire logic              resetn,     // Reset, active low
  input  wire logic [15:0]       reg_addr,   // Register address
  input  wire logic [15:0]       reg_wdata,  // Write data
  input  wire logic              reg_wr,     // Write strobe
  input  wire logic              reg_rd,     // Read strobe
  input  wire logic [15:0]       reg_rdata,  // Read data
  input  wire logic [63:0][31:0] param_in,   // Live parameters
  input  wire logic [15:0]       buf_addr,   // Buffer address
  input  wire logic [15:0]       buf_data,   // Buffer word
  input  wire logic [1:0]        log_status  // Logger state
);
  logic [15:0] mode_r;  // Trigger mode as last written
  // Decoded register writes
  wire run_wr   = reg_wr && reg_addr == logger_pkg::ADDR_RUN;
  wire start_wr = run_wr && reg_wdata == logger_pkg::RUN_ON;
  wire unmapped = reg_addr < 16'h9DED || reg_addr > 16'h9E02;

  // Shadow of the mode register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) mode_r <= 16'h0000;
    else if (reg_wr && reg_addr == logger_pkg::ADDR_MODE) mode_r <= reg_wdata;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Register port and state sequencing
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (reg_rd && unmapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (reg_rd && reg_addr == logger_pkg::ADDR_MODE
    |=> reg_rdata == $past(mode_r)) else $error("mode read back wrong");
  a_stop_idles: assert property (run_wr && reg_wdata != logger_pkg::RUN_ON &&
    log_status != logger_pkg::ST_DONE |=> log_status == logger_pkg::ST_IDLE)
    else $error("stop did not idle the logger");
  a_done_holds: assert property (log_status == logger_pkg::ST_DONE && !start_wr
    |=> log_status == logger_pkg::ST_DONE) else $error("done state left without start");
  a_idle_waits: assert property (log_status == logger_pkg::ST_IDLE && !start_wr
    |=> log_status == logger_pkg::ST_IDLE) else $error("capture began without start");
  a_idle_exit: assert property (log_status == logger_pkg::ST_IDLE
    |=> log_status inside {logger_pkg::ST_IDLE, logger_pkg::ST_ARMED})
    else $error("idle jumped past armed");
  a_cont_no_freeze: assert property (mode_r == logger_pkg::MODE_CONT && !reg_wr &&
    log_status == logger_pkg::ST_ARMED |=> log_status == logger_pkg::ST_ARMED)
    else $error("continuous mode left armed state");
  a_post_no_rearm: assert property (log_status == logger_pkg::ST_POST && !run_wr
    |=> log_status inside {logger_pkg::ST_POST, logger_pkg::ST_DONE})
    else $error("post-trigger capture went back");
  a_frozen_buffer: assert property (log_status == logger_pkg::ST_DONE && $stable(buf_addr)
    && $past(log_status) == logger_pkg::ST_DONE |=> $stable(buf_data))
    else $error("buffer changed after freeze");

  c_done: cover property (log_status == logger_pkg::ST_DONE);
  c_post: cover property (log_status == logger_pkg::ST_POST ##1 log_status == logger_pkg::ST_DONE);
  c_cont: cover property (mode_r == logger_pkg::MODE_CONT && log_status == logger_pkg::ST_ARMED);
endmodule

bind data_logger data_logger_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .param_in(param_in),
  .buf_addr(buf_addr), .buf_data(buf_data), .log_status(log_status));

// ===== test/data_logger_test.sv
// Self-checking bench for the data logger, one task per scenario.
// Assumes the design package is compiled first and the checker is bound.
`timescale 1ns/1ns
module data_logger_test;
  localparam int TICK = 100;  // Clocks per interval unit, shortened
  logic              clock;
  logic              resetn;
  logic [15:0]       reg_addr;
  logic [15:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [15:0]       reg_rdata;
  logic [63:0][31:0] param_in;
  logic [15:0]       buf_addr;
  logic [15:0]       buf_data;
  logic [1:0]        log_status;
  int                n_fail;
  int                n_tests;

  data_logger #(.TICK_CYCLES(TICK)) dut_u (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .param_in(param_in),
    .buf_addr(buf_addr), .buf_data(buf_data), .log_status(log_status));

  // Verdict and end of run
  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Register bus cycles
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    wr(a, d[31:16]);
    wr(a + 16'h0001, d[15:0]);
  endtask
  task automatic rchk(input string nm, input logic [15:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  task automatic wait_st(input logic [1:0] s, input int lim, output int n);
    n = 0;
    while (log_status !== s) begin
      @(posedge clock);
      #1;
      n++;
      if (n > lim) begin
        chk("log_status", {14'h0000, s}, {14'h0000, log_status});
        end_sim();
      end
    end
  endtask
  // Restart capture and look at the state three samples later
  task automatic try(input logic [1:0] e);
    wr(logger_pkg::ADDR_RUN, 16'h0000);
    wr(logger_pkg::ADDR_RUN, logger_pkg::RUN_ON);
    repeat (350) @(posedge clock);
    #1;
    chk("log_status", {14'h0000, e}, {14'h0000, log_status});
  endtask

  task automatic t_regs();
    rchk("cmp1 mask upper", logger_pkg::ADDR_CMP1_MASK, 16'hFFFF);
    rchk("cmp2 mask lower", logger_pkg::ADDR_CMP2_MASK + 16'h0001, 16'hFFFF);
    rchk("mode", logger_pkg::ADDR_MODE, 16'h0000);
    wr(16'h1234, 16'hBEEF);
    rchk("unmapped", 16'h1234, 16'h0000);
    wr32(logger_pkg::ADDR_EN_LOW, 32'h0000_000B);
    rchk("enable low", logger_pkg::ADDR_EN_LOW + 16'h0001, 16'h000B);
  endtask
  task automatic t_layout();
    logic [15:0] exp [4] = '{16'h0100, 16'hA5A5, 16'h5A5A, 16'h0103};
    int n;
    wr(logger_pkg::ADDR_INTERVAL, 16'h0001);
    wr(logger_pkg::ADDR_MODE, logger_pkg::MODE_ONE);
    wr(logger_pkg::ADDR_CMP1_INDEX, 16'h0003);
    wr(logger_pkg::ADDR_CMP1_KIND, logger_pkg::KIND_EQ);
    wr32(logger_pkg::ADDR_CMP1_REF, 32'h0000_0103);
    wr(logger_pkg::ADDR_RUN, logger_pkg::RUN_ON);
    wait_st(logger_pkg::ST_DONE, 400, n);
    rchk("status", logger_pkg::ADDR_STATUS, 16'h0003);
    rchk("freeze pointer", logger_pkg::ADDR_FREEZE_PTR, 16'h0004);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      buf_addr <= 16'(i);
      @(posedge clock);
      #1;
      chk("buffer word", exp[i], buf_data);
    end
  endtask
  task automatic t_kinds();
    logic [31:0] hit [4]  = '{32'h101, 32'h0FF, 32'h100, 32'h103};
    logic [31:0] miss [4] = '{32'h100, 32'h100, 32'h103, 32'h100};
    wr32(logger_pkg::ADDR_CMP1_MASK, 32'h0000_0F00);
    for (int k = 0; k < 4; k++) begin
      wr(logger_pkg::ADDR_CMP1_KIND, 16'(k));
      wr32(logger_pkg::ADDR_CMP1_REF, hit[k]);
      try(logger_pkg::ST_DONE);
      wr32(logger_pkg::ADDR_CMP1_REF, miss[k]);
      try(logger_pkg::ST_ARMED);
    end
  endtask
  task automatic t_modes();
    wr32(logger_pkg::ADDR_CMP1_MASK, 32'hFFFF_FFFF);
    wr(logger_pkg::ADDR_CMP1_KIND, logger_pkg::KIND_EQ);
    wr32(logger_pkg::ADDR_CMP1_REF, 32'h0000_0000);
    wr(logger_pkg::ADDR_CMP2_INDEX, 16'h0005);
    wr(logger_pkg::ADDR_CMP2_KIND, logger_pkg::KIND_EQ);
    wr32(logger_pkg::ADDR_CMP2_REF, 32'h0000_0105);
    try(logger_pkg::ST_ARMED);
    wr(logger_pkg::ADDR_MODE, logger_pkg::MODE_OR);
    try(logger_pkg::ST_DONE);
    wr(logger_pkg::ADDR_MODE, logger_pkg::MODE_AND);
    try(logger_pkg::ST_ARMED);
    wr32(logger_pkg::ADDR_CMP1_REF, 32'h0000_0103);
    try(logger_pkg::ST_DONE);
    wr(logger_pkg::ADDR_MODE, logger_pkg::MODE_CONT);
    try(logger_pkg::ST_ARMED);
    wr(logger_pkg::ADDR_RUN, 16'h0000);
    repeat (350) @(posedge clock);
    #1;
    chk("log_status", 16'h0000, {14'h0000, log_status});
  endtask
  task automatic t_timing();
    int n;
    wr(logger_pkg::ADDR_MODE, logger_pkg::MODE_ONE);
    wr(logger_pkg::ADDR_INTERVAL, 16'h0003);
    wr(logger_pkg::ADDR_RUN, logger_pkg::RUN_ON);
    wait_st(logger_pkg::ST_DONE, 600, n);
    rng("first sample delay", 3 * TICK, 3 * TICK + 100, n);
    wr(logger_pkg::ADDR_INTERVAL, 16'h0001);
    wr32(logger_pkg::ADDR_EN_LOW, 32'hFFFF_FFFF);
    wr32(logger_pkg::ADDR_EN_HIGH, 32'h003F_FFFF);
    wr(logger_pkg::ADDR_POST_PCT, 16'h0001);
    wr(logger_pkg::ADDR_RUN, logger_pkg::RUN_ON);
    wait_st(logger_pkg::ST_POST, 400, n);
    wait_st(logger_pkg::ST_DONE, 1200, n);
    rng("post-trigger span", 10 * TICK - 5, 10 * TICK + 5, n);
    rchk("freeze pointer", logger_pkg::ADDR_FREEZE_PTR, 16'h027E);
  endtask

  // Clock at 50 MHz
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Main sequence
  initial begin
    resetn    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    buf_addr  = 16'h0000;
    n_fail    = 0;
    n_tests   = 0;
    for (int i = 0; i < 64; i++) param_in[i] = 32'(256 + i);
    param_in[1] = 32'hA5A5_5A5A;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_layout();
    t_kinds();
    t_modes();
    t_timing();
    end_sim();
  end
endmodule
